// >>> hdl/fslseq_host.sv
module fslseq_host #(
   parameter logic [7:0] CMD_READ_ARRAY  = 8'h01,
   parameter logic [7:0] CMD_READ_STATUS = 8'h02,
   parameter logic [7:0] CMD_SUSPEND     = 8'h03,
   parameter logic [7:0] CMD_RESUME      = 8'h04,
   parameter logic [7:0] CMD_LOCK_SETUP  = 8'h05,
   parameter logic [7:0] CMD_SET_BLOCK   = 8'h06,
   parameter logic [7:0] CMD_SET_MASTER  = 8'h07,
   parameter logic [7:0] CMD_CLEAR_LOCKS = 8'h08
) (
   input  wire logic                   aclk,
   input  wire logic                   aresetn,
   input  wire logic                   ce,
   input  wire logic [7:0]             awaddr,
   input  wire logic                   awvalid,
   output logic                        awready,
   input  wire logic [31:0]            wdata,
   input  wire logic [3:0]             wstrb,
   input  wire logic                   wvalid,
   output logic                        wready,
   output logic [1:0]                  bresp,
   output logic                        bvalid,
   input  wire logic                   bready,
   input  wire logic [7:0]             araddr,
   input  wire logic                   arvalid,
   output logic                        arready,
   output logic [31:0]                 rdata,
   output logic [1:0]                  rresp,
   output logic                        rvalid,
   input  wire logic                   rready,
   input  wire logic [7:0]             dq_i,
   input  wire logic                   ready_busy_out,
   output fslseq_pkg::fslseq_pins_t    flash_o
);
   if (fslseq_pkg::OE_LOW_CYC > fslseq_pkg::CNT_MAX ||
       fslseq_pkg::WE_LOW_CYC > fslseq_pkg::CNT_MAX) begin : g_chk_cnt
      $error("Pulse width does not fit the cycle counter");
   end
   if (CMD_SET_BLOCK == CMD_SET_MASTER ||
       CMD_SET_BLOCK == CMD_CLEAR_LOCKS) begin : g_chk_cmd
      $error("Lock confirm codes must differ");
   end

   fslseq_pkg::fslseq_state_t state_q, state_d;
   fslseq_pkg::fslseq_stage_t stage_q, stage_d;
   fslseq_pkg::fslseq_op_t    op_q;
   fslseq_pkg::fslseq_pins_t  pins_q, pins_d;
   logic [7:0]  cnt_q, cnt_d;
   logic [19:0] addr_q, prog_addr_q;
   logic [7:0]  wdat_q, status_q, rdata_q;
   logic [2:0]  pinctl_q;
   logic        susp_q, prog_q, refused_q, undet_q;
   logic        bvalid_q, rvalid_q;
   logic [1:0]  bresp_q, rresp_q, wcnt_q;
   logic [31:0] rdata_bus_q;

   wire        busy     = state_q != fslseq_pkg::ST_IDLE;
   // Handshakes hold off while the clock enable freezes the block
   wire        wr_fire  = ce && awvalid && wvalid && !bvalid_q;
   wire        rd_fire  = ce && arvalid && !rvalid_q;
   wire [31:0] wmask    = {{8{wstrb[3]}}, {8{wstrb[2]}},
                           {8{wstrb[1]}}, {8{wstrb[0]}}};
   wire [31:0] addr_mrg = ({12'h000, addr_q} & ~wmask) | (wdata & wmask);
   wire [3:0]  req      = wdata[3:0];
   wire        hit_ctrl = wr_fire && wstrb[0] &&
                          awaddr == fslseq_pkg::OFF_CTRL;
   wire        hit_addr = wr_fire && awaddr == fslseq_pkg::OFF_ADDR && !busy;
   wire        hit_data = wr_fire && wstrb[0] && !busy &&
                          awaddr == fslseq_pkg::OFF_WDATA;
   wire        hit_pins = wr_fire && wstrb[0] &&
                          awaddr == fslseq_pkg::OFF_PINS;
   wire        wr_map   = awaddr == fslseq_pkg::OFF_CTRL ||
                          awaddr == fslseq_pkg::OFF_ADDR ||
                          awaddr == fslseq_pkg::OFF_WDATA ||
                          awaddr == fslseq_pkg::OFF_STAT ||
                          awaddr == fslseq_pkg::OFF_PINS;
   wire        rd_map   = araddr == fslseq_pkg::OFF_CTRL ||
                          araddr == fslseq_pkg::OFF_ADDR ||
                          araddr == fslseq_pkg::OFF_WDATA ||
                          araddr == fslseq_pkg::OFF_STAT ||
                          araddr == fslseq_pkg::OFF_PINS;

   wire susp_ok = req == fslseq_pkg::OP_RD_STATUS ||
                  req == fslseq_pkg::OP_POLL || req == fslseq_pkg::OP_RESUME ||
                  (req == fslseq_pkg::OP_RD_ARRAY && addr_q != prog_addr_q);
   wire idle_ok = req <= fslseq_pkg::OP_POLL &&
                  req != fslseq_pkg::OP_RESUME &&
                  (req != fslseq_pkg::OP_SUSPEND || prog_q);
   wire start   = hit_ctrl && !busy && (susp_q ? susp_ok : idle_ok);
   wire [3:0] op_n = start ? req : op_q;

   wire op_lock = op_q == fslseq_pkg::OP_SET_BLOCK ||
                  op_q == fslseq_pkg::OP_SET_MASTER ||
                  op_q == fslseq_pkg::OP_CLR_LOCKS;
   wire has_w2  = op_lock || op_q == fslseq_pkg::OP_BYTE_WRITE;
   wire do_read = op_lock || op_q == fslseq_pkg::OP_RD_STATUS ||
                  op_q == fslseq_pkg::OP_RD_ARRAY ||
                  op_q == fslseq_pkg::OP_SUSPEND || op_q == fslseq_pkg::OP_POLL;
   wire do_poll = do_read && op_q != fslseq_pkg::OP_RD_STATUS &&
                  op_q != fslseq_pkg::OP_RD_ARRAY;
   wire cnt_done   = cnt_q == 8'h00;
   wire poll_again = do_poll && !status_q[fslseq_pkg::SR_READY];
   wire want_clr   = op_lock && |(status_q & fslseq_pkg::SR_ERR_MASK);
   wire finish     = busy && state_d == fslseq_pkg::ST_IDLE;
   wire capture    = state_q == fslseq_pkg::ST_RD_LOW && cnt_done;

   wire [7:0] cmd1 =
      op_n == fslseq_pkg::OP_RD_ARRAY   ? CMD_READ_ARRAY :
      op_n == fslseq_pkg::OP_BYTE_WRITE ? fslseq_pkg::CMD_WRITE_SETUP :
      op_n == fslseq_pkg::OP_SUSPEND    ? CMD_SUSPEND :
      op_n == fslseq_pkg::OP_RESUME     ? CMD_RESUME :
      op_n == fslseq_pkg::OP_CLR_STATUS ? fslseq_pkg::CMD_CLEAR_STATUS :
      (op_n == fslseq_pkg::OP_SET_BLOCK || op_n == fslseq_pkg::OP_SET_MASTER ||
       op_n == fslseq_pkg::OP_CLR_LOCKS) ? CMD_LOCK_SETUP : CMD_READ_STATUS;
   wire [7:0] cmd2 =
      op_n == fslseq_pkg::OP_BYTE_WRITE ? wdat_q :
      op_n == fslseq_pkg::OP_SET_BLOCK  ? CMD_SET_BLOCK :
      op_n == fslseq_pkg::OP_SET_MASTER ? CMD_SET_MASTER : CMD_CLEAR_LOCKS;
   wire [7:0] cur_cmd =
      stage_d == fslseq_pkg::STG_W1 ? cmd1 :
      stage_d == fslseq_pkg::STG_W2 ? cmd2 : fslseq_pkg::CMD_CLEAR_STATUS;
   wire [7:0] cnt_ld =
      state_d == fslseq_pkg::ST_WR_LOW  ? 8'(fslseq_pkg::WE_LOW_CYC - 1) :
      state_d == fslseq_pkg::ST_WR_HIGH ? 8'(fslseq_pkg::WE_HI_CYC - 1) :
      state_d == fslseq_pkg::ST_RD_LOW  ? 8'(fslseq_pkg::OE_LOW_CYC - 1) :
      state_d == fslseq_pkg::ST_RD_HIGH ? 8'(fslseq_pkg::OE_HI_CYC - 1) :
      8'h00;

   always_comb begin
      state_d = state_q;
      stage_d = stage_q;
      unique case (state_q)
         fslseq_pkg::ST_IDLE: if (start) begin
            if (req == fslseq_pkg::OP_POLL) begin
               state_d = fslseq_pkg::ST_RD_LOW;
               stage_d = fslseq_pkg::STG_RD;
            end else begin
               state_d = fslseq_pkg::ST_WR_LOW;
               stage_d = fslseq_pkg::STG_W1;
            end
         end
         fslseq_pkg::ST_WR_LOW: if (cnt_done) begin
            state_d = fslseq_pkg::ST_WR_HIGH;
         end
         fslseq_pkg::ST_WR_HIGH: if (cnt_done) begin
            if (stage_q == fslseq_pkg::STG_W1 && has_w2) begin
               stage_d = fslseq_pkg::STG_W2;
               state_d = fslseq_pkg::ST_WR_LOW;
            end else if (stage_q != fslseq_pkg::STG_CLR && do_read) begin
               stage_d = fslseq_pkg::STG_RD;
               state_d = fslseq_pkg::ST_RD_LOW;
            end else begin
               state_d = fslseq_pkg::ST_IDLE;
            end
         end
         fslseq_pkg::ST_RD_LOW: if (cnt_done) begin
            state_d = fslseq_pkg::ST_RD_HIGH;
         end
         fslseq_pkg::ST_RD_HIGH: if (cnt_done) begin
            if (poll_again) begin
               state_d = fslseq_pkg::ST_RD_LOW;
            end else if (want_clr) begin
               stage_d = fslseq_pkg::STG_CLR;
               state_d = fslseq_pkg::ST_WR_LOW;
            end else begin
               state_d = fslseq_pkg::ST_IDLE;
            end
         end
         default: state_d = fslseq_pkg::ST_IDLE;
      endcase
   end

   assign cnt_d = (state_d != state_q) ? cnt_ld : cnt_q - 8'h01;
   assign pins_d = '{addr:   addr_q,
                     dq_o:   cur_cmd,
                     dq_oe:  state_d == fslseq_pkg::ST_WR_LOW ||
                             state_d == fslseq_pkg::ST_WR_HIGH,
                     ce_n:   state_d == fslseq_pkg::ST_IDLE,
                     oe_n:   state_d != fslseq_pkg::ST_RD_LOW,
                     we_n:   state_d != fslseq_pkg::ST_WR_LOW,
                     rp_n:   pinctl_q[fslseq_pkg::PC_RP_N],
                     rp_hv:  pinctl_q[fslseq_pkg::PC_RP_HV],
                     vpp_en: pinctl_q[fslseq_pkg::PC_VPP]};

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         state_q <= fslseq_pkg::ST_IDLE;
         stage_q <= fslseq_pkg::STG_W1;
         op_q    <= fslseq_pkg::OP_RD_STATUS;
         cnt_q   <= 8'h00;
         wcnt_q  <= 2'h0;
         pins_q  <= '{addr: 20'h0_0000, dq_o: 8'h00, dq_oe: 1'b0, ce_n: 1'b1,
                      oe_n: 1'b1, we_n: 1'b1, rp_n: 1'b1, rp_hv: 1'b0,
                      vpp_en: 1'b0};
      end else if (ce) begin
         state_q <= state_d;
         stage_q <= stage_d;
         cnt_q   <= cnt_d;
         pins_q  <= pins_d;
         if (start) begin
            op_q <= fslseq_pkg::fslseq_op_t'(req);
         end
         if (!busy) begin
            wcnt_q <= 2'h0;
         end else if (state_q == fslseq_pkg::ST_WR_LOW && cnt_done) begin
            wcnt_q <= wcnt_q + 2'h1;
         end
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         status_q    <= 8'h00;
         rdata_q     <= 8'h00;
         susp_q      <= 1'b0;
         prog_q      <= 1'b0;
         prog_addr_q <= 20'h0_0000;
      end else if (ce) begin
         if (capture && op_q == fslseq_pkg::OP_RD_ARRAY) begin
            rdata_q <= dq_i;
         end else if (capture && dq_i[fslseq_pkg::SR_READY]) begin
            // low bits taken only when ready
            status_q <= dq_i;
            if (!dq_i[fslseq_pkg::SR_PROG_SUSP] && !susp_q) begin
               prog_q <= 1'b0;
            end
         end else if (capture) begin
            status_q[fslseq_pkg::SR_READY] <= 1'b0;
         end
         if (finish && op_q == fslseq_pkg::OP_BYTE_WRITE) begin
            prog_q      <= 1'b1;
            prog_addr_q <= addr_q;
         end
         if (finish && op_q == fslseq_pkg::OP_SUSPEND &&
             status_q[fslseq_pkg::SR_PROG_SUSP]) begin
            susp_q <= 1'b1;
         end
         if (finish && op_q == fslseq_pkg::OP_RESUME) begin
            susp_q <= 1'b0;
         end
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         addr_q    <= 20'h0_0000;
         wdat_q    <= 8'h00;
         pinctl_q  <= fslseq_pkg::PINCTL_RST;
         refused_q <= 1'b0;
         undet_q   <= 1'b0;
      end else if (ce) begin
         if (hit_addr) begin
            addr_q <= addr_mrg[19:0];
         end
         if (hit_data) begin
            wdat_q <= wdata[7:0];
         end
         if (hit_pins && !susp_q) begin
            pinctl_q <= wdata[2:0];
         end
         if (start) begin
            refused_q <= 1'b0;
         end else if (hit_ctrl) begin
            refused_q <= 1'b1;
         end
         if (start && req == fslseq_pkg::OP_CLR_LOCKS) begin
            undet_q <= 1'b0;
         end else if (finish && op_q == fslseq_pkg::OP_CLR_LOCKS &&
                      status_q[fslseq_pkg::SR_SUPPLY]) begin
            undet_q <= 1'b1;
         end
         if (busy && op_q == fslseq_pkg::OP_CLR_LOCKS && hit_pins &&
             (!wdata[fslseq_pkg::PC_RP_N] || !wdata[fslseq_pkg::PC_VPP])) begin
            undet_q <= 1'b1;
         end
      end
   end

   wire [31:0] rd_mux =
      araddr == fslseq_pkg::OFF_CTRL  ? {28'h000_0000, op_q} :
      araddr == fslseq_pkg::OFF_ADDR  ? {12'h000, addr_q} :
      araddr == fslseq_pkg::OFF_WDATA ? {24'h00_0000, wdat_q} :
      araddr == fslseq_pkg::OFF_PINS  ? {29'h0000_0000, pinctl_q} :
      araddr == fslseq_pkg::OFF_STAT  ? {10'h000, prog_q, ready_busy_out,
                                         undet_q, refused_q, susp_q, busy,
                                         rdata_q, status_q} : 32'h0000_0000;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         bvalid_q    <= 1'b0;
         bresp_q     <= fslseq_pkg::RESP_OKAY;
         rvalid_q    <= 1'b0;
         rresp_q     <= fslseq_pkg::RESP_OKAY;
         rdata_bus_q <= 32'h0000_0000;
      end else if (ce) begin
         if (wr_fire) begin
            bvalid_q <= 1'b1;
            bresp_q  <= wr_map ? fslseq_pkg::RESP_OKAY :
                                 fslseq_pkg::RESP_SLVERR;
         end else if (bready) begin
            bvalid_q <= 1'b0;
         end
         if (rd_fire) begin
            rvalid_q    <= 1'b1;
            rdata_bus_q <= rd_mux;
            rresp_q     <= rd_map ? fslseq_pkg::RESP_OKAY :
                                    fslseq_pkg::RESP_SLVERR;
         end else if (rready) begin
            rvalid_q <= 1'b0;
         end
      end
   end

   assign awready = wr_fire;
   assign wready  = wr_fire;
   assign bvalid  = bvalid_q;
   assign bresp   = bresp_q;
   assign arready = rd_fire;
   assign rvalid  = rvalid_q;
   assign rresp   = rresp_q;
   assign rdata   = rdata_bus_q;
   assign flash_o = pins_q;

   susp_refuse_a: assert property (
      @(posedge aclk) disable iff (!aresetn || !ce)
      susp_q && hit_ctrl && req == fslseq_pkg::OP_BYTE_WRITE
      |=> refused_q && state_q == fslseq_pkg::ST_IDLE)
      else $error("Write accepted while suspended");
   pins_hold_a: assert property (
      @(posedge aclk) disable iff (!aresetn || !ce)
      susp_q |=> $stable(pinctl_q))
      else $error("Pin levels changed while suspended");
   two_writes_a: assert property (
      @(posedge aclk) disable iff (!aresetn || !ce)
      state_q == fslseq_pkg::ST_RD_LOW && op_lock |-> wcnt_q == 2'h2)
      else $error("Lock sequence without setup and confirm");
   we_width_a: assert property (
      @(posedge aclk) disable iff (!aresetn || !ce)
      $fell(flash_o.we_n) |-> !flash_o.we_n [*5] ##1 flash_o.we_n)
      else $error("Write strobe width wrong");
   err_clear_a: assert property (
      @(posedge aclk) disable iff (!aresetn || !ce)
      state_q == fslseq_pkg::ST_RD_HIGH && cnt_done && want_clr && !poll_again
      |=> ##1 !flash_o.we_n && flash_o.dq_o == fslseq_pkg::CMD_CLEAR_STATUS)
      else $error("Error status not cleared");
   ready_gate_a: assert property (
      @(posedge aclk) disable iff (!aresetn || !ce)
      $changed(status_q[6:0]) |-> $past(dq_i[fslseq_pkg::SR_READY]))
      else $error("Status taken while not ready");
   susp_entry_a: assert property (
      @(posedge aclk) disable iff (!aresetn || !ce)
      $rose(susp_q) |-> $past(op_q) == fslseq_pkg::OP_SUSPEND &&
      status_q[fslseq_pkg::SR_READY] && status_q[fslseq_pkg::SR_PROG_SUSP])
      else $error("Suspend flag without suspended status");
   undet_flag_a: assert property (
      @(posedge aclk) disable iff (!aresetn || !ce)
      busy && op_q == fslseq_pkg::OP_CLR_LOCKS && hit_pins &&
      !wdata[fslseq_pkg::PC_RP_N] |=> undet_q)
      else $error("Aborted clear not flagged");
   bus_excl_a: assert property (
      @(posedge aclk) disable iff (!aresetn)
      !flash_o.oe_n |-> flash_o.we_n && !flash_o.dq_oe)
      else $error("Read and write strobes overlap");
endmodule : fslseq_host

// >>> hdl/fslseq_pkg.sv
// Function
// - While suspended only other-location array read, status read, resume.
// - Host holds supply and reset/power-down levels steady while suspended.
// - Lock-bit set is a setup write followed by a confirm write.
// - Host checks write/set error after a set and clears status on error.
// - Aborted clear-locks leaves bits undetermined; host must repeat it. Host only sets undet_q, cleared when a new clear-locks starts.
// - Host ignores status bits 6 to 0 while ready flag reads zero.
package fslseq_pkg;
   localparam int unsigned CLK_NS      = 10;
   localparam int unsigned T_WE_LOW_NS = 50;
   localparam int unsigned T_WE_HI_NS  = 30;
   localparam int unsigned T_OE_LOW_NS = 120;
   localparam int unsigned T_OE_HI_NS  = 30;
   localparam int unsigned WE_LOW_CYC  = (T_WE_LOW_NS + CLK_NS - 1) / CLK_NS;
   localparam int unsigned WE_HI_CYC   = (T_WE_HI_NS + CLK_NS - 1) / CLK_NS;
   localparam int unsigned OE_LOW_CYC  = (T_OE_LOW_NS + CLK_NS - 1) / CLK_NS;
   localparam int unsigned OE_HI_CYC   = (T_OE_HI_NS + CLK_NS - 1) / CLK_NS;
   localparam int unsigned CNT_MAX     = 256;

   localparam int unsigned FL_ADDR_W = 20;

   localparam logic [7:0] OFF_CTRL  = 8'h00;
   localparam logic [7:0] OFF_ADDR  = 8'h04;
   localparam logic [7:0] OFF_WDATA = 8'h08;
   localparam logic [7:0] OFF_STAT  = 8'h0C;
   localparam logic [7:0] OFF_PINS  = 8'h10;

   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   localparam logic [7:0] CMD_WRITE_SETUP  = 8'h40;
   localparam logic [7:0] CMD_CLEAR_STATUS = 8'h50;

   localparam int SR_READY     = 7;
   localparam int SR_PROG_SUSP = 2;
   localparam int SR_SUPPLY    = 3;
   localparam logic [7:0] SR_ERR_MASK = 8'h3A;

   // Pin control bits: reset/power-down released, override level, supply on
   localparam int PC_RP_N  = 0;
   localparam int PC_RP_HV = 1;
   localparam int PC_VPP   = 2;
   localparam logic [2:0] PINCTL_RST = 3'h1;

   typedef enum logic [3:0] {
      OP_RD_STATUS  = 4'h0,
      OP_RD_ARRAY   = 4'h1,
      OP_BYTE_WRITE = 4'h2,
      OP_SUSPEND    = 4'h3,
      OP_RESUME     = 4'h4,
      OP_SET_BLOCK  = 4'h5,
      OP_SET_MASTER = 4'h6,
      OP_CLR_LOCKS  = 4'h7,
      OP_CLR_STATUS = 4'h8,
      OP_POLL       = 4'h9
   } fslseq_op_t;

   typedef enum logic [2:0] {
      ST_IDLE    = 3'h0,
      ST_WR_LOW  = 3'h1,
      ST_WR_HIGH = 3'h2,
      ST_RD_LOW  = 3'h3,
      ST_RD_HIGH = 3'h4
   } fslseq_state_t;

   typedef enum logic [1:0] {
      STG_W1  = 2'h0,
      STG_W2  = 2'h1,
      STG_RD  = 2'h2,
      STG_CLR = 2'h3
   } fslseq_stage_t;

   typedef struct packed {
      logic [FL_ADDR_W-1:0] addr;
      logic [7:0]           dq_o;
      logic                 dq_oe;
      logic                 ce_n;
      logic                 oe_n;
      logic                 we_n;
      logic                 rp_n;
      logic                 rp_hv;
      logic                 vpp_en;
   } fslseq_pins_t;
endpackage : fslseq_pkg

// >>> tb/fslseq_flash_model.sv
module fslseq_flash_model #(
   parameter logic [7:0]  CMD_READ_ARRAY  = 8'h01,
   parameter logic [7:0]  CMD_SUSPEND     = 8'h03,
   parameter logic [7:0]  CMD_RESUME      = 8'h04,
   parameter logic [7:0]  CMD_LOCK_SETUP  = 8'h05,
   parameter logic [7:0]  CMD_SET_BLOCK   = 8'h06,
   parameter logic [7:0]  CMD_SET_MASTER  = 8'h07,
   parameter logic [7:0]  CMD_CLEAR_LOCKS = 8'h08,
   parameter int unsigned BUSY_CYC        = 300
) (
   input  wire logic                     aclk,
   input  wire fslseq_pkg::fslseq_pins_t pins,
   output logic [7:0]                    dq_i,
   output logic                          ready_busy_out
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [7:0]  sr_q = 8'h80, last_q = 8'h00, prev_q = 8'h00, wbyte_q = 8'hFF;
   logic [19:0] waddr_q = 20'h0_0000;
   logic [15:0] blk_q = 16'h0000;
   logic        master_q = 1'b0, array_q = 1'b0, susp_q = 1'b0, we_q = 1'b1;
   int unsigned cnt_q = 0;
   logic [7:0]  stat, arr, cmd;
   logic [3:0]  blk;
   logic        rise, hv, lk;
   // ready in bit 7, write suspend in bit 2
   assign stat = {cnt_q == 0 || susp_q, sr_q[6:3], susp_q, sr_q[1:0]};
   assign ready_busy_out = stat[7];
   assign arr = (pins.addr == waddr_q) ? wbyte_q : ~pins.addr[7:0];
   // status unless array mode; released bus shows inverted last
   assign dq_i = (!pins.ce_n && !pins.oe_n) ? (array_q ? arr : stat) : ~last_q;
   // command taken at write strobe rise
   assign rise = pins.we_n && !we_q && !pins.ce_n;
   assign cmd = pins.dq_o;
   assign hv = pins.rp_hv;
   assign blk = pins.addr[19:16];
   assign lk = blk_q[blk] && !hv;
   always @(posedge aclk) begin
      we_q <= pins.we_n;
      if (!pins.ce_n && !pins.oe_n) last_q <= dq_i;
      if (cnt_q != 0 && !susp_q) cnt_q <= cnt_q - 1;
      if (rise) begin
         prev_q <= cmd;
         array_q <= 1'b0;
         if (prev_q == CMD_LOCK_SETUP) begin
            prev_q <= 8'h00;
            cnt_q <= 20;
            if (cmd == CMD_SET_BLOCK) begin
               blk_q[blk] <= blk_q[blk] | !master_q | hv;
               sr_q <= sr_q | ((master_q && !hv) ? 8'h12 : 8'h00);
            end else if (cmd == CMD_SET_MASTER) begin
               master_q <= master_q | hv;
               sr_q <= sr_q | (hv ? 8'h00 : 8'h12);
            end else if (cmd == CMD_CLEAR_LOCKS) begin
               sr_q <= sr_q | (!pins.vpp_en ? 8'h28 :
                               (master_q && !hv) ? 8'h22 : 8'h00);
               if (pins.vpp_en && (!master_q || hv)) blk_q <= 16'h0000;
            end else begin
               sr_q <= sr_q | 8'h30;
            end
         end else if (prev_q == fslseq_pkg::CMD_WRITE_SETUP) begin
            // locked block refuses write without override
            prev_q <= 8'h00;
            sr_q <= sr_q | (!pins.vpp_en ? 8'h18 : lk ? 8'h12 : 8'h00);
            if (pins.vpp_en && !lk) begin
               waddr_q <= pins.addr;
               wbyte_q <= cmd;
               cnt_q <= BUSY_CYC;
            end
         end else if (cmd == CMD_READ_ARRAY) begin
            array_q <= 1'b1;
         end else if (cmd == CMD_SUSPEND) begin
            susp_q <= cnt_q != 0;
         end else if (cmd == CMD_RESUME) begin
            susp_q <= 1'b0;
         // sticky errors, clear ignored in suspend
         end else if (cmd == fslseq_pkg::CMD_CLEAR_STATUS && !susp_q) begin
            sr_q <= sr_q & ~fslseq_pkg::SR_ERR_MASK;
         end
      end
   end
endmodule : fslseq_flash_model

// >>> tb/fslseq_host_tb.sv
module fslseq_host_tb;
   timeunit 1ns;
   timeprecision 1ns;
   localparam logic [7:0] PINS = fslseq_pkg::OFF_PINS;
   localparam logic [7:0] ADDR = fslseq_pkg::OFF_ADDR;
   logic                     aclk, aresetn, ce, ready_busy_out;
   logic [7:0]               awaddr, araddr, dq_i;
   logic [31:0]              wdata, rdata, st;
   logic [3:0]               wstrb;
   logic [1:0]               bresp, rresp, resp;
   logic                     awvalid, awready, wvalid, wready, bvalid, bready;
   logic                     arvalid, arready, rvalid, rready;
   fslseq_pkg::fslseq_pins_t flash_o;
   int                       err_count, n_tests;
   fslseq_host dut (.aclk, .aresetn, .ce, .awaddr, .awvalid, .awready, .wdata,
      .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid,
      .arready, .rdata, .rresp, .rvalid, .rready, .dq_i, .ready_busy_out,
      .flash_o);
   fslseq_flash_model flash (.aclk, .pins(flash_o), .dq_i, .ready_busy_out);
   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      n_tests++;
      if (seen !== exp) begin
         err_count++;
         $display("Error %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask : chk
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      do begin
         @(posedge aclk);
         if (awready) awvalid <= 1'b0;
         if (wready) wvalid <= 1'b0;
         if (bvalid) begin
            bready <= 1'b0;
            resp = bresp;
         end
      end while (awvalid || wvalid || bready);
   endtask : wr
   task automatic rd(input logic [7:0] a);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do begin
         @(posedge aclk);
         if (arready) arvalid <= 1'b0;
         if (rvalid) begin
            rready <= 1'b0;
            st = rdata;
            resp = rresp;
         end
      end while (arvalid || rready);
   endtask : rd
   // Start an operation and poll the busy bit
   task automatic op(input logic [3:0] code);
      wr(fslseq_pkg::OFF_CTRL, {28'h000_0000, code});
      do rd(fslseq_pkg::OFF_STAT); while (st[16] !== 1'b0);
   endtask : op
   task automatic t_regs;
      ce <= 1'b0;
      fork
         rd(PINS);
         begin
            repeat (4) @(posedge aclk);
            chk({6'h00, arready, rvalid}, 8'h00);
            ce <= 1'b1;
         end
      join
      chk(st[7:0], 8'h01);
      rd(8'h14);
      chk({6'h00, resp}, 8'h02);
      wr(8'h14, 32'h0000_0000);
      chk({6'h00, resp}, 8'h02);
      wr(PINS, 32'h0000_0001);
      chk({6'h00, resp}, 8'h00);
   endtask : t_regs
   task automatic t_lock;
      wr(PINS, 32'h0000_0005);
      op(4'h6);
      chk(st[7:0], 8'h92);
      op(4'h8);
      op(4'h0);
      chk(st[7:0], 8'h80);
      wr(PINS, 32'h0000_0007);
      op(4'h6);
      chk(st[7:0], 8'h80);
      wr(PINS, 32'h0000_0005);
      wr(ADDR, 32'h0001_0000);
      op(4'h5);
      chk(st[7:0], 8'h92);
      op(4'h8);
      wr(PINS, 32'h0000_0007);
      op(4'h5);
      chk(st[7:0], 8'h80);
      wr(PINS, 32'h0000_0005);
      op(4'h2);
      op(4'h9);
      chk(st[7:0], 8'h92);
      op(4'h8);
   endtask : t_lock
   task automatic t_clear;
      op(4'h7);
      chk(st[7:0], 8'hA2);
      wr(PINS, 32'h0000_0001);
      op(4'h7);
      chk(st[7:0], 8'hA8);
      chk(8'(st[20:16]), 8'h18);
      wr(PINS, 32'h0000_0007);
      op(4'h7);
      chk(st[7:0], 8'h80);
      chk(8'(st[20:16]), 8'h10);
      wr(fslseq_pkg::OFF_CTRL, 32'h0000_0007);
      wr(PINS, 32'h0000_0006);
      do rd(fslseq_pkg::OFF_STAT); while (st[16] !== 1'b0);
      chk(8'(st[20:16]), 8'h18);
      wr(PINS, 32'h0000_0007);
      op(4'h7);
      chk(8'(st[20:16]), 8'h10);
      wr(PINS, 32'h0000_0005);
      op(4'h2);
      op(4'h9);
      chk(st[7:0], 8'h80);
      op(4'h7);
      chk(st[7:0], 8'hA2);
   endtask : t_clear
   task automatic t_susp;
      wr(ADDR, 32'h0002_0010);
      wr(fslseq_pkg::OFF_WDATA, 32'h0000_003C);
      op(4'h2);
      op(4'h3);
      chk(st[7:0], 8'h84);
      chk(8'(st[20:16]), 8'h12);
      wr(ADDR, 32'h0000_0123);
      op(4'h1);
      chk(st[15:8], 8'hDC);
      op(4'h8);
      chk(8'(st[20:16]), 8'h16);
      op(4'h2);
      chk(8'(st[20:16]), 8'h16);
      op(4'h4);
      op(4'h9);
      chk(st[7:0], 8'h80);
      chk(8'(st[20:16]), 8'h10);
      wr(ADDR, 32'h0002_0010);
      op(4'h1);
      chk(st[15:8], 8'h3C);
   endtask : t_susp
   task automatic summarize;
      $display("Checks %0d, mismatches %0d", n_tests, err_count);
      if (err_count == 0 && n_tests > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask : summarize
   initial begin
      aclk = 1'b0;
      forever #5 aclk = ~aclk;
   end
   initial begin
      #300us;
      err_count++;
      summarize();
   end
   initial begin
      {aresetn, awvalid, wvalid, bready, arvalid, rready} <= '0;
      {awaddr, araddr, wdata} <= '0;
      wstrb <= 4'hF;
      ce <= 1'b1;
      repeat (6) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
      t_regs();
      t_lock();
      t_clear();
      t_susp();
      summarize();
   end
endmodule : fslseq_host_tb
